// ==== hw/bou_cfg.svh ====
/*
  Constants for the bitwise OR/XOR unit: function codes, widths, field
  positions and zero values. Assumes inclusion by its bare name.
*/
`ifndef BOU_CFG_SVH
`define BOU_CFG_SVH
`define BOU_WORD_W 16
`define BOU_DWORD_W 32
`define BOU_CODE_W 12
`define BOU_CODE_WORD_OR 12'h035
`define BOU_CODE_DWORD_OR 12'h611
`define BOU_CODE_WORD_XOR 12'h036
`define BOU_CODE_DWORD_XOR 12'h612
`define BOU_WORD_MSB 15
`define BOU_DWORD_MSB 31
`define BOU_LO_HI 15
`define BOU_LO_LO 0
`define BOU_HI_HI 31
`define BOU_HI_LO 16
`define BOU_ZERO_WORD 16'h0000
`define BOU_ZERO_DWORD 32'h0000_0000
`endif

// ==== hw/bou_pkg.sv ====
/*
  Types for the bitwise OR/XOR unit. Assumes bou_cfg.svh is on the
  include path.
*/
`include "bou_cfg.svh"
package bou_pkg;
  // Operand as seen by the unit: memory word pair or immediate constant
  typedef struct packed {
    logic is_const;
    logic [`BOU_DWORD_W-1:0] mem_val;
    logic [`BOU_DWORD_W-1:0] const_val;
  } bou_operand_s;

  // Condition flags
  typedef struct packed {
    logic error_flag;
    logic zero_flag;
    logic neg_flag;
  } bou_flags_s;

  // Write-back of the destination word pair
  typedef struct packed {
    logic wr_lo;
    logic wr_hi;
    logic [`BOU_WORD_W-1:0] lo;
    logic [`BOU_WORD_W-1:0] hi;
  } bou_dest_s;

  typedef enum logic [4:0] {
    BOU_NONE = 5'h01,
    BOU_WORD_OR_OP = 5'h02,
    BOU_DWORD_OR_OP = 5'h04,
    BOU_WORD_XOR_OP = 5'h08,
    BOU_DWORD_XOR_OP = 5'h10
  } bou_op_e;
endpackage : bou_pkg

// ==== hw/bou_unit.sv ====
/*
  Bitwise OR/XOR unit of the controller's logic instructions, single and
  double word. Assumes the sequencer presents code, operands and execution
  condition synchronous to clk_sys and writes dest back to memory.
*/
`timescale 1ns/1ps
`include "bou_cfg.svh"

module bou_unit
  import bou_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Instruction from the sequencer
  input wire logic exec_cond,
  input wire logic [`BOU_CODE_W-1:0] func_code,
  input wire bou_operand_s in1,
  input wire bou_operand_s in2,
  // Result
  output bou_dest_s dest,
  output bou_flags_s flags,
  output logic done
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Operand source select; memory data and constant both arrive
  // as a full word pair, the word operations read only the low word
  function automatic logic [`BOU_DWORD_W-1:0] pick(
    input bou_operand_s o
  );
    pick = o.is_const ? o.const_val : o.mem_val;
  endfunction : pick

  // Function code to one-hot operation; other codes do nothing
  function automatic bou_op_e decode_op(
    input logic [`BOU_CODE_W-1:0] code
  );
    case (code)
      `BOU_CODE_WORD_OR: decode_op = BOU_WORD_OR_OP;
      `BOU_CODE_DWORD_OR: decode_op = BOU_DWORD_OR_OP;
      `BOU_CODE_WORD_XOR: decode_op = BOU_WORD_XOR_OP;
      `BOU_CODE_DWORD_XOR: decode_op = BOU_DWORD_XOR_OP;
      default: decode_op = BOU_NONE;
    endcase
  endfunction : decode_op

  // Low word of a word pair, the word at R
  function automatic logic [`BOU_WORD_W-1:0] low_word(
    input logic [`BOU_DWORD_W-1:0] v
  );
    low_word = v[`BOU_LO_HI:`BOU_LO_LO];
  endfunction : low_word

  // High word of a word pair, the word at R+1
  function automatic logic [`BOU_WORD_W-1:0] high_word(
    input logic [`BOU_DWORD_W-1:0] v
  );
    high_word = v[`BOU_HI_HI:`BOU_HI_LO];
  endfunction : high_word

  // Zero test over the width the operation really has
  function automatic logic result_zero(
    input logic [`BOU_DWORD_W-1:0] v,
    input logic dword
  );
    if (dword)
      result_zero = (v == `BOU_ZERO_DWORD);
    else
      result_zero = (low_word(v) == `BOU_ZERO_WORD);
  endfunction : result_zero

  // Sign is the leftmost bit of the destination as written
  function automatic logic result_neg(
    input logic [`BOU_DWORD_W-1:0] v,
    input logic dword
  );
    if (dword)
      result_neg = v[`BOU_DWORD_MSB];
    else
      result_neg = v[`BOU_WORD_MSB];
  endfunction : result_neg

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire bou_op_e op;
  assign op = decode_op(func_code);

  wire logic is_dword;
  wire logic valid_op;
  assign is_dword = (op == BOU_DWORD_OR_OP) || (op == BOU_DWORD_XOR_OP);
  assign valid_op = (op != BOU_NONE);

  wire logic [`BOU_DWORD_W-1:0] a;
  wire logic [`BOU_DWORD_W-1:0] b;
  assign a = pick(in1);
  assign b = pick(in2);

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  // Word results are zero extended so hi reads back as zero
  logic [`BOU_DWORD_W-1:0] res;
  always_comb
  begin
    res = `BOU_ZERO_DWORD;
    case (op)
      BOU_WORD_OR_OP:
      begin
        res = {`BOU_ZERO_WORD, low_word(a) | low_word(b)};
      end
      BOU_DWORD_OR_OP:
      begin
        res = a | b;
      end
      BOU_WORD_XOR_OP:
      begin
        res = {`BOU_ZERO_WORD, low_word(a) ^ low_word(b)};
      end
      BOU_DWORD_XOR_OP:
      begin
        res = a ^ b;
      end
      default:
      begin
        res = `BOU_ZERO_DWORD;
      end
    endcase
  end

  wire logic res_zero;
  wire logic res_neg;
  assign res_zero = result_zero(res, is_dword);
  assign res_neg = result_neg(res, is_dword);

  // An unknown code with the condition on is refused like a
  // condition off, so stray codes never touch memory
  wire logic fire;
  assign fire = exec_cond && valid_op;

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  // Data and flags hold while idle; strobes are single pulses, so
  // memory is never rewritten without an execution
  bou_dest_s next_dest;
  bou_flags_s next_flags;
  logic next_done;
  always_comb
  begin
    next_dest = dest;
    next_flags = flags;
    next_done = fire;
    next_dest.wr_lo = fire;
    next_dest.wr_hi = fire && is_dword;
    if (fire)
    begin
      next_dest.lo = low_word(res);
      next_dest.hi = high_word(res);
      next_flags.error_flag = 1'b0;
      next_flags.zero_flag = res_zero;
      next_flags.neg_flag = res_neg;
    end
    else
    begin
      next_dest.lo = dest.lo;
      next_dest.hi = dest.hi;
      next_flags = flags;
    end
  end

  // ----------------------------------------------------------------
  // Result and flag registers
  // ----------------------------------------------------------------
  // Destination address is the sequencer's concern; it always names a
  // memory word, never a constant, so only data and strobes leave here
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      dest <= '0;
      flags <= '0;
      done <= 1'b0;
    end
    else
    begin
      dest <= next_dest;
      flags <= next_flags;
      done <= next_done;
    end
  end

endmodule : bou_unit

// ==== bench/bou_seq_model.sv ====
/* Operand source of the sequencer. Assumes bou_pkg. */
`timescale 1ns/1ps
module bou_seq_model
  import bou_pkg::*;
(
  // Operand
  input wire logic [31:0] w,
  output bou_operand_s op
);
  // Unused field inverted so a wrong pick shows
  assign op = {w[7], w[7] ? ~w : w, w[7] ? w : ~w};
endmodule : bou_seq_model

// ==== bench/bou_unit_assertions.sv ====
/* Port checker for bou_unit. Assumes bou_pkg. */
`timescale 1ns/1ps
module bou_assertions
  import bou_pkg::*;
(
  // Ports of the unit
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic exec_cond,
  input wire logic [11:0] func_code,
  input wire bou_operand_s in1,
  input wire bou_operand_s in2,
  input wire bou_dest_s dest,
  input wire bou_flags_s flags,
  input wire logic done
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!$sampled(resetn));
  wire tk = exec_cond &
    (func_code inside {12'h035, 12'h036, 12'h611, 12'h612});
  wire dw = func_code[9];
  wire [31:0] a = in1.is_const ? in1.const_val : in1.mem_val;
  wire [31:0] b = in2.is_const ? in2.const_val : in2.mem_val;
  wire [31:0] r = (func_code[0] ? a | b : a ^ b) & {{16{dw}}, 16'hffff};
  sequence s_pulse;
    done && dest.wr_lo;
  endsequence
  a_take_pulse: assert property (tk |=> s_pulse)
    else $error("no pulse");
  a_pulse_cause: assert property (done |-> $past(tk))
    else $error("stray pulse");
  a_result_val: assert property (
    tk |=> {dest.hi, dest.lo} == $past(r)) else $error("bad result");
  a_hi_strobe: assert property (tk |=> dest.wr_hi == $past(dw))
    else $error("bad strobe");
  a_zero_flag: assert property (
    done |-> flags.zero_flag == ({dest.hi, dest.lo} == 0)) else $error("zero");
  a_neg_flag: assert property (
    done |-> flags.neg_flag == (dest.wr_hi ? dest.hi[15] : dest.lo[15]))
    else $error("neg");
  a_err_clear: assert property (done |-> !flags.error_flag)
    else $error("error flag");
  a_idle_hold: assert property (
    !tk |=> !dest.wr_lo && $stable(dest.lo) && $stable(flags))
    else $error("idle change");
endmodule : bou_assertions
bind bou_unit bou_assertions u_chk (.*);

// ==== bench/tb_bitwise_or_xor_unit.sv ====
/* Random ops against a model. Assumes the design files. */
`timescale 1ns/1ps
module tb_bitwise_or_xor_unit;
  import bou_pkg::*;
  logic clk_sys = 0, resetn = 0, exec_cond = 0;
  logic [11:0] func_code = 12'h000;
  logic [11:0] codes [5] = '{12'h035, 12'h611, 12'h036, 12'h612, 12'h034};
  logic [31:0] w1 = 32'h0, w2 = 32'h0;
  logic [37:0] e = '0;
  wire bou_dest_s dq;
  wire bou_flags_s fq;
  wire dn;
  wire [37:0] q = {dn, dq, fq};
  integer errors = 0, comparisons = 0, k, r;
  bou_operand_s in1, in2;
  bou_seq_model m1 (.w(w1), .op(in1));
  bou_seq_model m2 (.w(w2), .op(in2));
  bou_unit dut (.clk_sys(clk_sys), .resetn(resetn), .exec_cond(exec_cond),
    .func_code(func_code), .in1(in1), .in2(in2), .done(dn),
    .dest(dq), .flags(fq));
  initial forever #50 clk_sys = ~clk_sys;
  task chk;
    comparisons++;
    if (q !== e)
    begin
      errors++;
      $display("unexpected %0t: %h", $time, q);
    end
  endtask : chk
  task report_and_stop;
    if (errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    void'($urandom(80));
    repeat (16) @(posedge clk_sys);
    resetn <= 1;
    repeat (600)
    begin
      @(posedge clk_sys);
      k = $urandom % 5;
      r = $urandom;
      exec_cond <= |r[5:4];
      func_code <= codes[k];
      w1 <= r;
      w2 <= r[8] ? $urandom : r;
      #1 chk;
      e[37:35] = 3'h0;
      if (exec_cond && k < 4)
      begin
        r = k[1] ? w1 ^ w2 : w1 | w2;
        r = k[0] ? r : r & 32'hffff;
        e = {2'b11, k[0], r[15:0], r[31:16], 1'b0, r == 0, r[k[0]*16+15]};
      end
    end
    report_and_stop;
  end
endmodule : tb_bitwise_or_xor_unit
